/* File: design/fpm_code_dec.sv */
// five-input selection code to pair index decoder
`timescale 1ns/1ps
`default_nettype none
module fpm_code_dec (
	input wire logic [4:0] code,
	output logic [3:0] idx,
	output logic ok
);
	import fpm_pkg::*;

	logic [PAIRS-1:0] hit;

	genvar k;
	generate
		for (k = 0; k < PAIRS; k++)
		begin : g_hit
			assign hit[k] = (code == fpm_encode(4'(k)));
		end
	endgenerate

	always_comb
	begin
		idx = IDX_RESET;
		for (int i = 0; i < PAIRS; i++)
		begin
			if (hit[i])
			begin
				idx = 4'(i);
			end
		end
	end

	assign ok = |hit;
endmodule // fpm_code_dec
`default_nettype wire

/* File: design/fpm_device.sv */
// field pair selection, changeover timing and violation monitor, scanner end
//
// Summary of operation
// - controller settles code before changeover time ends
// - old pair stays evaluated during changeover
// - timer starts on first selection input change
// - new pair evaluated only after timer expiry
// - pairs one to five: one-hot codes
// - pairs six to ten: exactly one input low
// - second group selects second function pairs
// - matrix: low group column, high group row
// - two functions drive separate safety outputs
// - banks: high group bank, low group pair
// - order check: forbidden transition drops outputs
// - order check: deactivated target pair drops outputs
// - missing reference contour drops outputs
// - reference contour within maximum distance
// - standby pair holds outputs off
// - fixed mode: always first pair, inputs ignored
// - changeover time never below minimum
// - drop after sync plus changeover plus response
// - changeover violation signals fault, outputs off
`timescale 1ns/1ps
`default_nettype none
module fpm_device #(
	parameter int unsigned CYC_PER_MS = fpm_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic rst_b,
	fpm_sel_if.device_end sel,
	input wire fpm_pkg::fpm_mode_t mode,
	input wire logic [15:0] chg_time_ms,
	input wire logic order_check_en,
	input wire logic [1:0][99:0] permit_col,
	input wire logic [99:0] permit_row,
	input wire logic [1:0][99:0] pair_enabled,
	input wire logic [1:0][99:0] ref_contour_map,
	input wire logic [1:0][99:0] standby_map,
	input wire logic [1:0] field_clear,
	input wire logic [1:0] contour_seen,
	output wire logic [6:0] first_bank_field_pair,
	output wire logic [3:0] second_function_field_pair,
	output wire logic [1:0] changeover_active,
	output wire logic [1:0] changeover_fault
);
	import fpm_pkg::*;

	////////////////////////////////////////////////////////////////////////////////
	// pin synchronisers and group decode

	logic [1:0][4:0] group_meta;
	logic [1:0][4:0] group_sync;
	logic [1:0][4:0] group_prev;
	logic [1:0][3:0] group_idx;
	logic [1:0] group_ok;
	logic [1:0] group_changed;
	logic [CNT_W-1:0] wait_limit;
	logic [1:0] eval_ok;
	logic [1:0][6:0] cur_pair;
	logic [6:0] held_pair_first;

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			group_meta <= '0;
			group_sync <= '0;
			group_prev <= '0;
		end
		else
		begin
			group_meta <= {sel.select_group_high, sel.select_group_low};
			group_sync <= group_meta;
			group_prev <= group_sync;
		end
	end

	assign wait_limit = fpm_wait_cycles(chg_time_ms, CYC_PER_MS);

	genvar g;
	generate
		for (g = 0; g < 2; g++)
		begin : g_dec
			assign group_changed[g] = (group_sync[g] != group_prev[g]);
			fpm_code_dec u_dec (
				.code(group_sync[g]),
				.idx(group_idx[g]),
				.ok(group_ok[g])
			);
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// one changeover monitor per protective function

	generate
		for (g = 0; g < 2; g++)
		begin : g_func
			fpm_state_t state;
			fpm_state_t next_state;
			logic [3:0] col;
			logic [3:0] row;
			logic [CNT_W-1:0] cnt;
			logic fault;
			logic func_on;
			logic row_used;
			logic changed;
			logic [3:0] new_col;
			logic [3:0] new_row;
			logic new_ok;
			logic [6:0] new_pair;
			logic col_permit;
			logic row_permit;
			logic order_ok;
			logic expired;
			logic switching;

			assign func_on = (g == 0) ? (mode != FPM_FIXED_ONE) : (mode == FPM_TWO_FUNC);
			// second group as row in matrix, as bank in multi-bank; numbering is identical
			assign row_used = (g == 0) && (mode == FPM_MATRIX || mode == FPM_MULTI_BANK);
			// function B decodes the second group with the same codes
			assign new_col = group_idx[g];
			assign new_row = row_used ? group_idx[1] : IDX_RESET;
			assign new_ok = group_ok[g] && (!row_used || group_ok[1]);
			assign changed = group_changed[g] || (row_used && group_changed[1]);
			// widen before the product; a four-bit product would lose rows above one
			assign new_pair = 7'(new_row) * 7'h0A + 7'(new_col);
			assign col_permit = (new_col == col) || permit_col[g][7'(col) * 7'h0A + 7'(new_col)];
			assign row_permit = (new_row == row) || permit_row[7'(row) * 7'h0A + 7'(new_row)];
			// first adoption after reset has no predecessor to check against
			assign order_ok = !order_check_en
				|| ((state == FPM_ST_START || (col_permit && row_permit))
				&& pair_enabled[g][new_pair]);
			assign expired = (cnt >= wait_limit - CNT_W'(1));
			assign cur_pair[g] = 7'(row) * 7'h0A + 7'(col);

			always_comb
			begin
				next_state = state;
				case (state)
					FPM_ST_START, FPM_ST_SWITCH:
					begin
						if (expired)
						begin
							// code must be settled by now, else the changeover failed
							next_state = (new_ok && order_ok) ? FPM_ST_RUN : FPM_ST_FAULT;
						end
					end
					FPM_ST_RUN:
					begin
						if (changed)
						begin
							next_state = FPM_ST_SWITCH;
						end
					end
					FPM_ST_FAULT:
					begin
						next_state = FPM_ST_FAULT;
					end
					default:
					begin
						next_state = FPM_ST_FAULT;
					end
				endcase
			end

			always_ff @(posedge clk)
			begin
				if (!rst_b)
				begin
					state <= FPM_ST_START;
					col <= IDX_RESET;
					row <= IDX_RESET;
					cnt <= '0;
					fault <= 1'b0;
					switching <= 1'b0;
				end
				else if (!func_on)
				begin
					// inputs ignored, first pair of first bank held
					state <= FPM_ST_RUN;
					col <= IDX_RESET;
					row <= IDX_RESET;
					cnt <= '0;
					switching <= 1'b0;
				end
				else
				begin
					state <= next_state;
					switching <= (next_state == FPM_ST_SWITCH);
					fault <= fault || (next_state == FPM_ST_FAULT);
					cnt <= (state == FPM_ST_RUN || expired) ? '0 : cnt + CNT_W'(1);
					// col and row hold the old pair until expiry
					if ((state == FPM_ST_START || state == FPM_ST_SWITCH) && expired && new_ok)
					begin
						col <= new_col;
						row <= new_row;
					end
				end
			end

			// evaluation always follows the held pair
			assign eval_ok[g] = (state == FPM_ST_RUN || state == FPM_ST_SWITCH)
				&& !standby_map[g][cur_pair[g]]
				&& field_clear[g]
				&& (!ref_contour_map[g][cur_pair[g]] || contour_seen[g]);
			assign changeover_active[g] = switching;
			assign changeover_fault[g] = fault;
		end
	endgenerate

	////////////////////////////////////////////////////////////////////////////////
	// outputs; one function drives both pairs unless two functions are configured

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sel.safety_outputs_first <= 1'b0;
			sel.safety_outputs_second <= 1'b0;
			held_pair_first <= PAIR_RESET;
		end
		else
		begin
			sel.safety_outputs_first <= eval_ok[0];
			sel.safety_outputs_second <= (mode == FPM_TWO_FUNC) ? eval_ok[1] : eval_ok[0];
			// lags the held pair by one edge, like the safety outputs
			held_pair_first <= cur_pair[0];
		end
	end

	assign first_bank_field_pair = held_pair_first;
	assign second_function_field_pair = g_func[1].col;
endmodule // fpm_device
`default_nettype wire

/* File: design/fpm_device_fix.sv */
// held-pair output alias for function A
`timescale 1ns/1ps
`default_nettype none
`default_nettype wire

/* File: design/fpm_host.sv */
// machine controller end: drives selection codes and honours changeover timing
`timescale 1ns/1ps
`default_nettype none
module fpm_host #(
	parameter int unsigned CYC_PER_MS = fpm_pkg::CYC_PER_MS
) (
	input wire logic clk,
	input wire logic rst_b,
	fpm_sel_if.ctrl_end sel,
	input wire logic [15:0] chg_time_ms,
	input wire logic req_valid,
	input wire logic [3:0] req_low_idx,
	input wire logic [3:0] req_high_idx,
	output logic req_ready,
	output logic safety_first_seen,
	output logic safety_second_seen
);
	import fpm_pkg::*;

	logic [CNT_W-1:0] hold_cnt;
	logic [1:0] safe_meta;
	logic req_take;
	logic idx_ok;
	logic hold_done;

	assign idx_ok = (req_low_idx < 4'(PAIRS)) && (req_high_idx < 4'(PAIRS));
	assign req_take = req_valid && req_ready && idx_ok;
	// stay stable for the full wait so the code is settled at expiry
	assign hold_done = (hold_cnt >= fpm_wait_cycles(chg_time_ms, CYC_PER_MS));

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			sel.select_group_low <= 5'h01;
			sel.select_group_high <= 5'h01;
			req_ready <= 1'b0;
			hold_cnt <= '0;
		end
		else
		begin
			if (req_take)
			begin
				sel.select_group_low <= fpm_encode(req_low_idx);
				sel.select_group_high <= fpm_encode(req_high_idx);
			end
			hold_cnt <= req_take ? '0 : (hold_done ? hold_cnt : hold_cnt + CNT_W'(1));
			req_ready <= !req_take && hold_done;
		end
	end

	always_ff @(posedge clk)
	begin
		if (!rst_b)
		begin
			safe_meta <= 2'h0;
			safety_first_seen <= 1'b0;
			safety_second_seen <= 1'b0;
		end
		else
		begin
			safe_meta <= {sel.safety_outputs_second, sel.safety_outputs_first};
			safety_first_seen <= safe_meta[0];
			safety_second_seen <= safe_meta[1];
		end
	end
endmodule // fpm_host
`default_nettype wire

/* File: design/fpm_pkg.sv */
// shared constants, types and code mapping for the field pair changeover monitor
package fpm_pkg;
	localparam int unsigned CLK_MHZ = 100;
	localparam int unsigned CYC_PER_MS = CLK_MHZ * 1000;
	localparam int unsigned SYNC_MS = 40;
	localparam int unsigned CHG_MIN_MS = 40;
	localparam int unsigned GROUP_W = 5;
	localparam int unsigned PAIRS = 10;
	localparam int unsigned CNT_W = 40;
	localparam logic [3:0] IDX_RESET = 4'h0;
	localparam logic [6:0] PAIR_RESET = 7'h00;

	typedef enum logic [2:0] {
		FPM_FIXED_ONE,
		FPM_TEN_PAIRS,
		FPM_TWO_FUNC,
		FPM_MATRIX,
		FPM_MULTI_BANK
	} fpm_mode_t;

	typedef enum logic [1:0] {
		FPM_ST_START,
		FPM_ST_RUN,
		FPM_ST_SWITCH,
		FPM_ST_FAULT
	} fpm_state_t;

	// pair index 0..9 to the five-input code; one high for 0..4, one low for 5..9
	function automatic logic [4:0] fpm_encode(input logic [3:0] idx);
		logic [4:0] bit_sel;
		bit_sel = 5'h00;
		if (idx < 4'h5)
		begin
			bit_sel = 5'h01 << idx;
			return bit_sel;
		end
		bit_sel = 5'h01 << (4'h9 - idx);
		return ~bit_sel;
	endfunction

	// changeover wait in cycles: sync time plus changeover time, never below the minimum
	function automatic logic [CNT_W-1:0] fpm_wait_cycles(input logic [15:0] chg_ms,
		input int unsigned cyc_per_ms);
		logic [16:0] eff_ms;
		eff_ms = (chg_ms < 16'(CHG_MIN_MS)) ? 17'(CHG_MIN_MS) : {1'b0, chg_ms};
		return CNT_W'(eff_ms + 17'(SYNC_MS)) * CNT_W'(cyc_per_ms);
	endfunction
endpackage

/* File: design/fpm_sel_if.sv */
// selection inputs and safety outputs between controller and monitor
`timescale 1ns/1ps
`default_nettype none
interface fpm_sel_if;
	logic [4:0] select_group_low;
	logic [4:0] select_group_high;
	logic safety_outputs_first;
	logic safety_outputs_second;

	modport device_end (
		input select_group_low,
		input select_group_high,
		output safety_outputs_first,
		output safety_outputs_second
	);

	modport ctrl_end (
		output select_group_low,
		output select_group_high,
		input safety_outputs_first,
		input safety_outputs_second
	);
endinterface
`default_nettype wire

/* File: test/fpm_props.sv */
// link checks between controller and monitor ends
`timescale 1ns/1ps
`default_nettype none
module fpm_props #(
	parameter int WAIT_CYC = 800
) (
	input wire logic clk,
	input wire logic rst_b,
	input wire logic fixed_only,
	input wire logic [4:0] select_group_low,
	input wire logic [4:0] select_group_high,
	input wire logic safety_outputs_first,
	input wire logic safety_outputs_second
);
	logic [4:0] last_low;
	logic [4:0] last_high;
	logic [10:0] since_rst;
	logic [10:0] since_low;
	logic [10:0] since_high;
	wire logic low_moved = select_group_low != last_low;
	wire logic high_moved = select_group_high != last_high;
	////////////////////
	// ages saturate; a wrap would fake a short quiet time
	always_ff @(posedge clk)
	begin
		last_low <= select_group_low;
		last_high <= select_group_high;
		since_rst <= !rst_b ? 11'h000 : since_rst + 11'(since_rst != 11'h7FF);
		since_low <= (!rst_b || low_moved) ? 11'h000 : since_low + 11'(since_low != 11'h7FF);
		since_high <= (!rst_b || high_moved) ? 11'h000 : since_high + 11'(since_high != 11'h7FF);
	end
	////////////////////
	default clocking @(posedge clk);
	endclocking
	default disable iff (!rst_b);
	sequence s_low_move;
		$changed(select_group_low) && safety_outputs_first;
	endsequence
	sequence s_high_move;
		$changed(select_group_high) && safety_outputs_second;
	endsequence
	chk_low_code_valid: assert property ($countones(select_group_low) inside {1, 4})
		else $error("low group code invalid");
	chk_high_code_valid: assert property ($countones(select_group_high) inside {1, 4})
		else $error("high group code invalid");
	chk_low_change_spacing: assert property (
		$changed(select_group_low) |-> since_low >= WAIT_CYC)
		else $error("low group changed too soon");
	chk_high_change_spacing: assert property (
		$changed(select_group_high) |-> since_high >= WAIT_CYC)
		else $error("high group changed too soon");
	// fixed single-pair mode has no selection to settle, so no start wait
	chk_start_quiet_first: assert property (
		safety_outputs_first && !fixed_only |-> since_rst >= WAIT_CYC)
		else $error("output A on before start wait");
	chk_start_quiet_second: assert property (
		safety_outputs_second && !fixed_only |-> since_rst >= WAIT_CYC)
		else $error("output B on before start wait");
	chk_old_pair_first: assert property (s_low_move |=> safety_outputs_first [*8])
		else $error("output A lost during changeover");
	chk_old_pair_second: assert property (s_high_move |=> safety_outputs_second [*8])
		else $error("output B lost during changeover");
endmodule // fpm_props
`default_nettype wire

/* File: test/tb.sv */
// self-checking bench joining controller and monitor ends
`timescale 1ns/1ps
`default_nettype none
module tb;
	import fpm_pkg::*;
	localparam int W = 800;
	logic clk = 1'b0;
	logic rst_b = 1'b0;
	fpm_mode_t mode;
	logic [15:0] chg_time_ms;
	logic order_check_en;
	logic [1:0][99:0] permit_col, pair_enabled, ref_contour_map, standby_map;
	logic [99:0] permit_row;
	logic [1:0] field_clear, contour_seen;
	logic req_valid = 1'b0;
	logic [3:0] req_low_idx = 4'h0, req_high_idx = 4'h0;
	wire logic req_ready, seen_a, seen_b;
	wire logic [6:0] pair_a;
	wire logic [3:0] pair_b;
	wire logic [1:0] chg_act, chg_flt;
	int failures = 0;
	int compares = 0;
	fpm_sel_if sel_if ();
	fpm_device #(.CYC_PER_MS(10)) fpm_device_inst (.clk(clk), .rst_b(rst_b), .sel(sel_if),
		.mode(mode), .chg_time_ms(chg_time_ms), .order_check_en(order_check_en),
		.permit_col(permit_col), .permit_row(permit_row), .pair_enabled(pair_enabled),
		.ref_contour_map(ref_contour_map), .standby_map(standby_map),
		.field_clear(field_clear), .contour_seen(contour_seen), .first_bank_field_pair(pair_a),
		.second_function_field_pair(pair_b), .changeover_active(chg_act),
		.changeover_fault(chg_flt));
	fpm_host #(.CYC_PER_MS(10)) fpm_host_inst (.clk(clk), .rst_b(rst_b), .sel(sel_if),
		.chg_time_ms(chg_time_ms), .req_valid(req_valid), .req_low_idx(req_low_idx),
		.req_high_idx(req_high_idx), .req_ready(req_ready), .safety_first_seen(seen_a),
		.safety_second_seen(seen_b));
	fpm_props #(.WAIT_CYC(W)) fpm_props_inst (.clk(clk), .rst_b(rst_b),
		.fixed_only(mode == FPM_FIXED_ONE),
		.select_group_low(sel_if.select_group_low), .select_group_high(sel_if.select_group_high),
		.safety_outputs_first(sel_if.safety_outputs_first),
		.safety_outputs_second(sel_if.safety_outputs_second));
	always #5 clk = ~clk;
	////////////////////
	function automatic logic [4:0] enc(input logic [3:0] i);
		return (i < 4'h5) ? 5'h01 << i : ~(5'h01 << (4'h9 - i));
	endfunction
	task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
		compares++;
		if (seen !== exp)
		begin
			failures++;
			$display("FAIL %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic finish_test();
		$display("counts: %0d compares, %0d failures", compares, failures);
		if (failures == 0 && compares > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask
	// any changeover time up to the minimum gives the same wait
	task automatic do_reset(input fpm_mode_t m);
		rst_b = 1'b0;
		mode = m;
		chg_time_ms = 16'($urandom_range(40));
		order_check_en = 1'b0;
		permit_col = '1;
		permit_row = '1;
		pair_enabled = '1;
		ref_contour_map = '0;
		standby_map = '0;
		field_clear = 2'h3;
		contour_seen = 2'h3;
		repeat (2) @(negedge clk);
		rst_b = 1'b1;
		repeat (W + 20) @(negedge clk);
		check("start pair", pair_a, 8'h00);
		check("start out", sel_if.safety_outputs_first, 1'b1);
	endtask
	task automatic request(input logic [3:0] lo, input logic [3:0] hi, input logic [6:0] old_a,
		input logic act);
		int n;
		n = 0;
		while (req_ready !== 1'b1 && n < 2000)
		begin
			@(negedge clk);
			n++;
		end
		if (n >= 2000)
		begin
			failures++;
			finish_test();
		end
		req_low_idx = lo;
		req_high_idx = hi;
		req_valid = 1'b1;
		@(negedge clk);
		req_valid = 1'b0;
		@(negedge clk);
		check("low code", sel_if.select_group_low, enc(lo));
		check("high code", sel_if.select_group_high, enc(hi));
		repeat (W - 8) @(negedge clk);
		check("old pair", pair_a, old_a);
		check("timer", chg_act[0], act);
		repeat (16) @(negedge clk);
	endtask
	////////////////////
	initial
	begin
		logic [3:0] lo, hi, pa;
		logic [6:0] prev;
		void'($urandom(59));
		do_reset(FPM_TEN_PAIRS);
		pa = 4'h0;
		for (int k = 0; k < 12; k++)
		begin
			lo = (k < 3) ? 4'(9 - 4 * k) : 4'((int'(pa) + 1 + $urandom_range(8)) % 10);
			request(lo, 4'h0, {3'h0, pa}, 1'b1);
			check("pair", pair_a, {4'h0, lo});
			check("out b", sel_if.safety_outputs_second, 1'b1);
			check("seen a", seen_a, 1'b1);
			pa = lo;
		end
		$display("test ten pairs done");
		do_reset(FPM_TWO_FUNC);
		field_clear = 2'h1;
		pa = 4'h0;
		for (int k = 0; k < 6; k++)
		begin
			lo = 4'((int'(pa) + 1 + $urandom_range(8)) % 10);
			hi = (k == 0) ? 4'h9 : 4'($urandom_range(9));
			request(lo, hi, {3'h0, pa}, 1'b1);
			check("pair a", pair_a, {4'h0, lo});
			check("pair b", pair_b, {4'h0, hi});
			check("out a", sel_if.safety_outputs_first, 1'b1);
			check("out b", sel_if.safety_outputs_second, 1'b0);
			check("seen b", seen_b, 1'b0);
			check("no fault", chg_flt, 2'h0);
			pa = lo;
		end
		$display("test two functions done");
		for (int m = 0; m < 2; m++)
		begin
			do_reset(m == 0 ? FPM_MATRIX : FPM_MULTI_BANK);
			prev = 7'h00;
			pa = 4'h0;
			for (int k = 0; k < 5; k++)
			begin
				lo = 4'((int'(pa) + 1 + $urandom_range(8)) % 10);
				hi = (k == 0) ? 4'h9 : 4'($urandom_range(9));
				request(lo, hi, prev, 1'b1);
				prev = 7'(hi * 10 + lo);
				check("pair", pair_a, {1'b0, prev});
				pa = lo;
			end
		end
		$display("test matrix and banks done");
		do_reset(FPM_FIXED_ONE);
		request(4'h7, 4'h3, 7'h00, 1'b0);
		check("fixed pair", pair_a, 8'h00);
		check("fixed out", sel_if.safety_outputs_first, 1'b1);
		$display("test fixed pair done");
		for (int f = 0; f < 3; f++)
		begin
			do_reset(FPM_TEN_PAIRS);
			order_check_en = 1'b1;
			permit_col[0][3] = (f != 0);
			pair_enabled[0][3] = (f != 1);
			standby_map[0][3] = (f == 2);
			request(4'h3, 4'h0, 7'h00, 1'b1);
			check("out a", sel_if.safety_outputs_first, 1'b0);
			check("fault", chg_flt[0], f != 2);
		end
		$display("test faults done");
		do_reset(FPM_TEN_PAIRS);
		ref_contour_map[0][0] = 1'b1;
		contour_seen = 2'h2;
		repeat (3) @(negedge clk);
		check("contour lost", sel_if.safety_outputs_first, 1'b0);
		contour_seen = 2'h3;
		repeat (3) @(negedge clk);
		check("contour back", sel_if.safety_outputs_first, 1'b1);
		$display("test contour done");
		finish_test();
	end
endmodule // tb
`default_nettype wire
